// *** pkg/fbr_pkg.sv ***
// Constants, types and helpers shared by the banked floating-point register file
// Notes on behaviour
// - Thirty-two 32-bit words in two banks of sixteen
// - Active singles follow the bank-select field
// - Extended singles always use the inactive bank
// - Doubles pair active singles, even word upper
// - Four vectors group four consecutive active singles
// - Extended doubles pair inactive-bank singles, even upper
// - Matrix view exposes all sixteen inactive words
// - Status resets with flush on, round-to-zero
// - Status bits 22 to 31 read zero
// - Pair-move-size selects 32 or 64 bit moves
// - Double-width mode selects precision, disables graphics ops
// - Denormal flush mode treats denormals as zero
// - Cause field bits 17..12: E V Z O U I
// - Enable field bits 11..7, no unit-error enable
// - Flag field bits 6..2, no unit-error flag
// - Each operation first clears the cause field
// - Exceptions set cause and sticky flag bits
// - Rounding code 00 nearest, 01 zero, others reserved
// - Transfer register carries words between core and unit
// - Absent sources read cause zero, flag unchanged
// - Taken enabled exception leaves destination unmodified
`default_nettype none
package fbr_pkg;
    localparam int FBR_WORDS    = 32;
    localparam int FBR_WORD_W   = 32;
    localparam int FBR_SC_W     = 22;
    localparam int FBR_BANK_BIT = 21;
    localparam int FBR_SZ_BIT   = 20;
    localparam int FBR_PR_BIT   = 19;
    localparam int FBR_DN_BIT   = 18;
    localparam int FBR_CAUSE_HI = 17;
    localparam int FBR_CAUSE_LO = 12;
    localparam int FBR_EN_HI    = 11;
    localparam int FBR_EN_LO    = 7;
    localparam int FBR_FLAG_HI  = 6;
    localparam int FBR_FLAG_LO  = 2;
    localparam int FBR_RM_HI    = 1;
    localparam int FBR_RM_LO    = 0;
    // Source vector order: [5]=unit error, [4]=invalid, [3]=div0, [2]=overflow, [1]=underflow, [0]=inexact
    localparam int FBR_SRC_E    = 5;
    localparam logic [31:0] FBR_SC_RESET   = 32'h0004_0001;
    localparam logic [31:0] FBR_XFER_RESET = 32'h0000_0000;
    localparam logic [31:0] FBR_WORD_RESET = 32'h0000_0000;
    localparam logic [1:0]  FBR_RM_NEAREST = 2'h0;
    localparam logic [1:0]  FBR_RM_ZERO    = 2'h1;

    // Read views, Gray coded
    typedef enum logic [1:0] {
        FBR_VIEW_SINGLE  = 2'b00,
        FBR_VIEW_DOUBLE  = 2'b01,
        FBR_VIEW_XDOUBLE = 2'b11,
        FBR_VIEW_XSINGLE = 2'b10
    } fbr_view_t;

    // Physical word address from bank and index
    function automatic logic [4:0] fbr_phys(input logic bank, input logic [3:0] idx);
        return {bank, idx};
    endfunction : fbr_phys

    // Pick one word out of the flat storage image
    function automatic logic [31:0] fbr_word(input logic [1023:0] w, input logic [4:0] a);
        return w[32*a +: 32];
    endfunction : fbr_word
endpackage : fbr_pkg
`default_nettype wire

// *** verilog/fbr_bank_mem.sv ***
// Physical word storage with two word write ports and a flat registered image
`default_nettype none
module fbr_bank_mem import fbr_pkg::*; #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Write port a
    input  wire logic                   we_a,
    input  wire logic [AW-1:0]          addr_a,
    input  wire logic [WIDTH-1:0]       data_a,
    // Write port b, wins on equal address
    input  wire logic                   we_b,
    input  wire logic [AW-1:0]          addr_b,
    input  wire logic [WIDTH-1:0]       data_b,
    // All words, straight from the storage flops
    output logic      [DEPTH*WIDTH-1:0] words
);
    // Storage update
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            words <= '0;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (we_b && addr_b == AW'(i)) begin
                    words[WIDTH*i +: WIDTH] <= data_b;
                end else if (we_a && addr_a == AW'(i)) begin
                    words[WIDTH*i +: WIDTH] <= data_a;
                end
            end
        end
    end
endmodule : fbr_bank_mem
`default_nettype wire

// *** verilog/fbr_status_ctl.sv ***
// Status/control register with exception cause and sticky flag handling
`default_nettype none
module fbr_status_ctl import fbr_pkg::*; (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Software access and bank toggle
    input  wire logic                sc_we,
    input  wire logic [31:0]         sc_wdata,
    input  wire logic                bank_toggle,
    // Operation sequencing
    input  wire logic                op_start,
    input  wire logic                op_done,
    input  wire logic [5:0]          exc_src,
    // State
    output logic      [FBR_SC_W-1:0] sc,
    output logic                     next_bank
);
    logic [FBR_SC_W-1:0] next_sc;

    // Next value: write, then bank toggle, then hardware events
    always_comb begin
        next_sc = sc;
        if (sc_we) begin
            next_sc = sc_wdata[FBR_SC_W-1:0];
        end
        if (bank_toggle) begin
            next_sc[FBR_BANK_BIT] = ~next_sc[FBR_BANK_BIT];
        end
        if (op_start) begin
            next_sc[FBR_CAUSE_HI:FBR_CAUSE_LO] = '0;
        end
        if (op_done) begin
            next_sc[FBR_CAUSE_HI:FBR_CAUSE_LO] = next_sc[FBR_CAUSE_HI:FBR_CAUSE_LO] | exc_src;
            next_sc[FBR_FLAG_HI:FBR_FLAG_LO] = next_sc[FBR_FLAG_HI:FBR_FLAG_LO] | exc_src[4:0];
        end
        next_bank = next_sc[FBR_BANK_BIT];
    end

    // Register with documented reset value
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sc <= FBR_SC_RESET[FBR_SC_W-1:0];
        end else begin
            sc <= next_sc;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    reset_value_a: assert property ($rose(rst_n) |-> sc == 22'h04_0001)
        else $error("status not at reset value after reset");
    cause_clear_a: assert property (op_start && !op_done && !sc_we |=> sc[17:12] == 6'h00)
        else $error("cause field not cleared at operation start");
    cause_set_a: assert property (op_done |=> (sc[17:12] & $past(exc_src)) == $past(exc_src))
        else $error("cause bit missing after exception");
    flag_sticky_a: assert property (!sc_we |=> ($past(sc[6:2]) & ~sc[6:2]) == 5'h00)
        else $error("flag bit dropped without software write");
    flag_set_a: assert property (op_done ##1 !sc_we |-> ##1 ($past(exc_src[4:0], 2) & ~sc[6:2]) == 5'h00)
        else $error("flag bit lost after exception");
endmodule : fbr_status_ctl
`default_nettype wire

// *** verilog/fbr_regfile.sv ***
// Banked floating-point register file with views, status/control and transfer register
`default_nettype none
module fbr_regfile import fbr_pkg::*; #(
    parameter int WORD_W = 32
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Status/control load and store
    input  wire logic          sc_we,
    input  wire logic [31:0]   sc_wdata,
    output logic      [31:0]   sc_rdata,
    input  wire logic          bank_toggle,
    // Transfer register, core side and unit side
    input  wire logic          xfer_we,
    input  wire logic [31:0]   xfer_wdata,
    input  wire logic          xfer_fpu_we,
    input  wire logic [31:0]   xfer_fpu_wdata,
    output logic      [31:0]   xfer_rdata,
    // Operation sequencing
    input  wire logic          op_start,
    input  wire logic          op_done,
    input  wire logic [5:0]    exc_src,
    output logic               exc_taken,
    // Result writeback
    input  wire logic          res_we,
    input  wire logic [3:0]    res_idx,
    input  wire logic [63:0]   res_data,
    // Moves into the register file
    input  wire logic          mov_we,
    input  wire logic          mov_ext,
    input  wire logic [3:0]    mov_idx,
    input  wire logic [63:0]   mov_data,
    // Indexed read port
    input  wire fbr_view_t     rd_view,
    input  wire logic [3:0]    rd_idx,
    output logic      [63:0]   rd_data,
    // Vector and matrix views
    input  wire logic [1:0]    vec_idx,
    output logic      [127:0]  vec_data,
    output logic      [511:0]  mtx_data,
    // Mode outputs
    output logic               bank_select,
    output logic               pair_move_size,
    output logic               double_width_ops,
    output logic               denorm_flush_mode,
    output logic      [1:0]    round_select,
    output logic               graphics_undef,
    output logic               mode_reserved
);
    logic [FBR_SC_W-1:0]         sc;
    logic                        next_bank;
    logic [FBR_WORDS*WORD_W-1:0] words;
    logic                        res_commit;
    logic                        w_ext;
    logic                        w_pair;
    logic                        w_bank;
    logic [3:0]                  w_idx;
    logic [63:0]                 w_data;
    logic                        we_a;
    logic                        we_b;
    logic [4:0]                  addr_a;
    logic [4:0]                  addr_b;
    logic [31:0]                 data_a;
    logic [31:0]                 data_b;
    logic                        act_bank;
    logic                        ext_bank;
    logic [3:0]                  even_idx;
    logic [3:0]                  odd_idx;

    // Status/control register and exception bookkeeping
    fbr_status_ctl u_status (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .sc_we     (sc_we),
        .sc_wdata  (sc_wdata),
        .bank_toggle (bank_toggle),
        .op_start  (op_start),
        .op_done   (op_done),
        .exc_src   (exc_src),
        .sc        (sc),
        .next_bank (next_bank)
    );

    // Physical storage of both banks
    fbr_bank_mem #(
        .WIDTH (WORD_W),
        .DEPTH (FBR_WORDS),
        .AW    (5)
    ) u_mem (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .we_a    (we_a),
        .addr_a  (addr_a),
        .data_a  (data_a),
        .we_b    (we_b),
        .addr_b  (addr_b),
        .data_b  (data_b),
        .words   (words)
    );

    // Status read image and mode decode
    assign sc_rdata          = {10'h000, sc};
    assign bank_select       = sc[FBR_BANK_BIT];
    assign pair_move_size    = sc[FBR_SZ_BIT];
    assign double_width_ops  = sc[FBR_PR_BIT];
    assign denorm_flush_mode = sc[FBR_DN_BIT];
    assign round_select      = sc[FBR_RM_HI:FBR_RM_LO];
    assign graphics_undef    = sc[FBR_PR_BIT];
    assign mode_reserved     = (sc[FBR_SZ_BIT] & sc[FBR_PR_BIT]) | sc[FBR_RM_HI];

    // Bank mapping uses the value being written this cycle
    assign act_bank = next_bank;
    assign ext_bank = ~next_bank;

    // Unit error cannot be masked; enabled sources trap
    assign exc_taken  = op_done & (exc_src[FBR_SRC_E] | |(exc_src[4:0] & sc[FBR_EN_HI:FBR_EN_LO]));
    assign res_commit = op_done & res_we & ~exc_taken;

    // Write steering: a committed result has priority over a move
    always_comb begin
        w_ext    = res_commit ? 1'b0 : mov_ext;
        w_idx    = res_commit ? res_idx : mov_idx;
        w_data   = res_commit ? res_data : mov_data;
        w_pair   = res_commit ? sc[FBR_PR_BIT] : sc[FBR_SZ_BIT];
        w_bank   = act_bank ^ w_ext;
        even_idx = {w_idx[3:1], 1'b0};
        odd_idx  = {w_idx[3:1], 1'b1};
        we_a     = res_commit | mov_we;
        we_b     = we_a & w_pair;
        addr_a   = fbr_phys(w_bank, w_pair ? even_idx : w_idx);
        addr_b   = fbr_phys(w_bank, odd_idx);
        data_a   = w_pair ? w_data[63:32] : w_data[31:0];
        data_b   = w_data[31:0];
    end

    // Indexed read port
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            unique case (rd_view)
                FBR_VIEW_SINGLE: begin
                    rd_data <= {32'h0000_0000, fbr_word(words, fbr_phys(act_bank, rd_idx))};
                end
                FBR_VIEW_DOUBLE: begin
                    rd_data <= {fbr_word(words, fbr_phys(act_bank, {rd_idx[3:1], 1'b0})),
                                fbr_word(words, fbr_phys(act_bank, {rd_idx[3:1], 1'b1}))};
                end
                FBR_VIEW_XDOUBLE: begin
                    rd_data <= {fbr_word(words, fbr_phys(ext_bank, {rd_idx[3:1], 1'b0})),
                                fbr_word(words, fbr_phys(ext_bank, {rd_idx[3:1], 1'b1}))};
                end
                FBR_VIEW_XSINGLE: begin
                    rd_data <= {32'h0000_0000, fbr_word(words, fbr_phys(ext_bank, rd_idx))};
                end
            endcase
        end
    end

    // Vector view, lowest-numbered single in the top word
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vec_data <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                vec_data[96-32*i +: 32] <= fbr_word(words, fbr_phys(act_bank, {vec_idx, i[1:0]}));
            end
        end
    end

    // Matrix view over the whole inactive bank
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mtx_data <= '0;
        end else begin
            for (int i = 0; i < 16; i++) begin
                mtx_data[480-32*i +: 32] <= fbr_word(words, fbr_phys(ext_bank, i[3:0]));
            end
        end
    end

    // Transfer register; the core side wins a same-cycle clash
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xfer_rdata <= FBR_XFER_RESET;
        end else if (xfer_we) begin
            xfer_rdata <= xfer_wdata;
        end else if (xfer_fpu_we) begin
            xfer_rdata <= xfer_fpu_wdata;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    reserved_zero_a: assert property (sc_rdata[31:22] == 10'h000)
        else $error("reserved status bits not zero");
    single_map_a: assert property (rd_view == FBR_VIEW_SINGLE |=>
            rd_data[31:0] == $past(words[32*{next_bank, rd_idx} +: 32]))
        else $error("single read from wrong bank");
    ext_map_a: assert property (rd_view == FBR_VIEW_XSINGLE |=>
            rd_data[31:0] == $past(words[32*{~next_bank, rd_idx} +: 32]))
        else $error("extended read from wrong bank");
    double_pair_a: assert property (rd_view == FBR_VIEW_DOUBLE |=>
            rd_data == {$past(words[32*{next_bank, rd_idx[3:1], 1'b0} +: 32]),
                        $past(words[32*{next_bank, rd_idx[3:1], 1'b1} +: 32])})
        else $error("double view halves wrong");
    matrix_view_a: assert property (##1 mtx_data[511:480] == $past(words[32*{~next_bank, 4'h0} +: 32]))
        else $error("matrix first element wrong");
    vector_view_a: assert property (##1 vec_data[31:0] == $past(words[32*{next_bank, vec_idx, 2'b11} +: 32]))
        else $error("vector last element wrong");
    trap_hold_a: assert property (exc_taken && !mov_we |=> words == $past(words))
        else $error("destination changed on taken exception");
    single_write_a: assert property (res_commit && !sc[FBR_PR_BIT] |=>
            words[32*$past({next_bank, res_idx}) +: 32] == $past(res_data[31:0]))
        else $error("single result not written");
    bank_switch_a: assert property (sc_we && rd_view == FBR_VIEW_SINGLE |=>
            rd_data[31:0] == $past(words[32*{sc_wdata[FBR_BANK_BIT] ^ bank_toggle, rd_idx} +: 32]))
        else $error("old bank mapping seen after write");
    xfer_store_a: assert property (xfer_we |=> xfer_rdata == $past(xfer_wdata))
        else $error("transfer register not loaded");

    double_write_c: cover property (res_commit && sc[FBR_PR_BIT]);
    bank_flip_c: cover property (bank_toggle && rd_view == FBR_VIEW_SINGLE);
    trap_c: cover property (exc_taken && res_we);
    pair_move_c: cover property (mov_we && sc[FBR_SZ_BIT]);
endmodule : fbr_regfile
`default_nettype wire

// *** tb/fbr_core_model.sv ***
// Core-side model that issues status loads, moves, operations, reads and transfers
`default_nettype none
module fbr_core_model import fbr_pkg::*; (
    // Clock
    input  wire logic       sys_clk,
    // Requests towards the register file
    output var logic        sc_we,
    output var logic [31:0] sc_wdata,
    output var logic        bank_toggle,
    output var logic        xfer_we,
    output var logic [31:0] xfer_wdata,
    output var logic        xfer_fpu_we,
    output var logic [31:0] xfer_fpu_wdata,
    output var logic        op_start,
    output var logic        op_done,
    output var logic [5:0]  exc_src,
    output var logic        res_we,
    output var logic [3:0]  res_idx,
    output var logic [63:0] res_data,
    output var logic        mov_we,
    output var logic        mov_ext,
    output var logic [3:0]  mov_idx,
    output var logic [63:0] mov_data,
    output var fbr_view_t   rd_view,
    output var logic [3:0]  rd_idx,
    output var logic [1:0]  vec_idx,
    // Answer
    input  wire logic       exc_taken
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle values from time zero
    initial begin
        {sc_we, sc_wdata, bank_toggle, xfer_we, xfer_wdata, xfer_fpu_we, xfer_fpu_wdata} = '0;
        {op_start, op_done, exc_src, res_we, res_idx, res_data} = '0;
        {mov_we, mov_ext, mov_idx, mov_data, rd_idx, vec_idx} = '0;
        rd_view = FBR_VIEW_SINGLE;
    end

    // Move to just after the next rising edge
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step

    // Status load; a well-behaved core keeps reserved bits and codes clear
    task automatic sc_store(input logic [31:0] d, input bit raw);
        step();
        if (!raw) begin
            d[31:22] = '0;
            d[1] = 1'b0;
            if (d[20]) d[19] = 1'b0;
        end
        sc_we = 1'b1;
        sc_wdata = d;
        step();
        sc_we = 1'b0;
    endtask : sc_store

    // Move into the active or the extended bank
    task automatic move(input logic ext, input logic [3:0] idx, input logic [63:0] d);
        step();
        {mov_we, mov_ext, mov_idx, mov_data} = {1'b1, ext, idx, d};
        step();
        mov_we = 1'b0;
    endtask : move

    // Read request, optionally with a bank toggle in the same cycle
    task automatic read(input fbr_view_t v, input logic [3:0] idx, input logic [1:0] vi, input logic tog);
        step();
        {bank_toggle, rd_idx, vec_idx} = {tog, idx, vi};
        rd_view = v;
        step();
        bank_toggle = 1'b0;
    endtask : read

    // Operation start
    task automatic begin_op();
        step();
        op_start = 1'b1;
        step();
        op_start = 1'b0;
    endtask : begin_op

    // Operation end with sources and a result write; reports the taken flag
    task automatic end_op(input logic [5:0] src, input logic [3:0] idx, input logic [63:0] d, output logic taken);
        step();
        {op_done, exc_src, res_we, res_idx, res_data} = {1'b1, src, 1'b1, idx, d};
        #1;
        taken = exc_taken;
        step();
        {op_done, res_we} = 2'h0;
    endtask : end_op

    // Transfer register writes from the core and the unit
    task automatic xfer(input logic cw, input logic [31:0] cd, input logic fw, input logic [31:0] fd);
        step();
        {xfer_we, xfer_wdata, xfer_fpu_we, xfer_fpu_wdata} = {cw, cd, fw, fd};
        step();
        {xfer_we, xfer_fpu_we} = 2'h0;
    endtask : xfer
endmodule : fbr_core_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the banked floating-point register file
`default_nettype none
module tb import fbr_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;

    logic         sys_clk = 1'b0;
    logic         rst_n   = 1'b0;
    logic         sc_we, bank_toggle, xfer_we, xfer_fpu_we, op_start, op_done, res_we, mov_we, mov_ext, exc_taken;
    logic         bank_select, pair_move_size, double_width_ops, denorm_flush_mode, graphics_undef, mode_reserved;
    logic [31:0]  sc_wdata, sc_rdata, xfer_wdata, xfer_fpu_wdata, xfer_rdata;
    logic [5:0]   exc_src;
    logic [3:0]   res_idx, mov_idx, rd_idx;
    logic [63:0]  res_data, mov_data, rd_data;
    logic [1:0]   vec_idx, round_select;
    logic [127:0] vec_data;
    logic [511:0] mtx_data;
    fbr_view_t    rd_view;
    logic         tk;
    logic [4:0]   fl;
    int           n_fail     = 0;
    int           num_checks = 0;
    logic [31:0]  tbl [8] = '{32'h0000_0000, 32'h0020_0000, 32'h0010_0000, 32'h0008_0001,
                              32'h0004_0000, 32'h0003_F000, 32'h0000_0F80, 32'h0000_007C};

    // Clock at 125 MHz
    always #4 sys_clk = ~sys_clk;

    // Design and core model
    fbr_regfile u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .sc_we(sc_we), .sc_wdata(sc_wdata), .sc_rdata(sc_rdata),
        .bank_toggle(bank_toggle), .xfer_we(xfer_we), .xfer_wdata(xfer_wdata), .xfer_fpu_we(xfer_fpu_we),
        .xfer_fpu_wdata(xfer_fpu_wdata), .xfer_rdata(xfer_rdata), .op_start(op_start), .op_done(op_done),
        .exc_src(exc_src), .exc_taken(exc_taken), .res_we(res_we), .res_idx(res_idx), .res_data(res_data),
        .mov_we(mov_we), .mov_ext(mov_ext), .mov_idx(mov_idx), .mov_data(mov_data), .rd_view(rd_view),
        .rd_idx(rd_idx), .rd_data(rd_data), .vec_idx(vec_idx), .vec_data(vec_data), .mtx_data(mtx_data),
        .bank_select(bank_select), .pair_move_size(pair_move_size), .double_width_ops(double_width_ops),
        .denorm_flush_mode(denorm_flush_mode), .round_select(round_select), .graphics_undef(graphics_undef),
        .mode_reserved(mode_reserved));
    fbr_core_model u_core (
        .sys_clk(sys_clk), .sc_we(sc_we), .sc_wdata(sc_wdata), .bank_toggle(bank_toggle), .xfer_we(xfer_we),
        .xfer_wdata(xfer_wdata), .xfer_fpu_we(xfer_fpu_we), .xfer_fpu_wdata(xfer_fpu_wdata),
        .op_start(op_start), .op_done(op_done), .exc_src(exc_src), .res_we(res_we), .res_idx(res_idx),
        .res_data(res_data), .mov_we(mov_we), .mov_ext(mov_ext), .mov_idx(mov_idx), .mov_data(mov_data),
        .rd_view(rd_view), .rd_idx(rd_idx), .vec_idx(vec_idx), .exc_taken(exc_taken));

    // Compare and count
    task automatic chk(input logic [511:0] got, input logic [511:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk

    // Distinct word pattern per bank and index
    function automatic logic [31:0] wv(input logic b, input logic [3:0] i);
        return {4'hA, 3'h0, b, 20'h0_0000, i};
    endfunction : wv

    // Walk every view with active bank b
    task automatic views(input logic b);
        logic [511:0] m;
        logic [127:0] v;
        logic [3:0]   e;
        for (int k = 0; k < 16; k++) m[511-32*k -: 32] = wv(!b, k[3:0]);
        for (int i = 0; i < 16; i++) begin
            e = i[3:0] & 4'hC;
            v = {wv(b, e), wv(b, e + 4'h1), wv(b, e + 4'h2), wv(b, e + 4'h3)};
            u_core.read(FBR_VIEW_SINGLE, i[3:0], i[3:2], 1'b0);
            chk(rd_data, {32'h0, wv(b, i[3:0])}, "single view");
            chk(vec_data, v, "vector view");
            chk(mtx_data, m, "matrix view");
            u_core.read(FBR_VIEW_XSINGLE, i[3:0], 2'h0, 1'b0);
            chk(rd_data, {32'h0, wv(!b, i[3:0])}, "extended single view");
            u_core.read(FBR_VIEW_DOUBLE, i[3:0] & 4'hE, 2'h0, 1'b0);
            chk(rd_data, {wv(b, i[3:0] & 4'hE), wv(b, i[3:0] | 4'h1)}, "double view");
            u_core.read(FBR_VIEW_XDOUBLE, i[3:0] & 4'hE, 2'h0, 1'b0);
            chk(rd_data, {wv(!b, i[3:0] & 4'hE), wv(!b, i[3:0] | 4'h1)}, "extended double view");
        end
    endtask : views

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog well beyond the expected run length
    initial begin
        #50_000;
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk(sc_rdata, 32'h0004_0001, "status reset value");
        chk({denorm_flush_mode, round_select, xfer_rdata}, {1'b1, 2'h1, 32'h0}, "mode reset");
        foreach (tbl[j]) begin
            u_core.sc_store(tbl[j], 1'b0);
            chk(sc_rdata, tbl[j], "status image");
            chk({bank_select, pair_move_size, double_width_ops, denorm_flush_mode, graphics_undef, mode_reserved,
                 round_select}, {tbl[j][21:18], tbl[j][19], 1'b0, tbl[j][1:0]}, "mode outputs");
        end
        // Reserved combination and rounding code are stored but reported
        u_core.sc_store(32'h0018_0002, 1'b1);
        chk({mode_reserved, graphics_undef, round_select}, {1'b1, 1'b1, 2'h2}, "reserved report");
        u_core.sc_store(32'hFFC0_0001, 1'b1);
        chk(sc_rdata, 32'h0000_0001, "reserved bits");
        for (int i = 0; i < 16; i++) begin
            u_core.move(1'b0, i[3:0], {32'h5555_5555, wv(1'b0, i[3:0])});
            u_core.move(1'b1, i[3:0], {32'h5555_5555, wv(1'b1, i[3:0])});
        end
        views(1'b0);
        u_core.read(FBR_VIEW_SINGLE, 4'h0, 2'h0, 1'b1);
        chk(rd_data, {32'h0, wv(1'b1, 4'h0)}, "mapping after toggle");
        views(1'b1);
        u_core.sc_store(32'h0030_0001, 1'b0);
        u_core.move(1'b0, 4'h5, 64'h1234_5678_9ABC_DEF0);
        u_core.read(FBR_VIEW_DOUBLE, 4'h4, 2'h0, 1'b0);
        chk(rd_data, 64'h1234_5678_9ABC_DEF0, "pair move");
        // Each source alone, enables off: cause follows, flags accumulate
        u_core.sc_store(32'h0000_0000, 1'b0);
        fl = 5'h0;
        for (int s = 0; s < 6; s++) begin
            u_core.begin_op();
            chk(sc_rdata[17:12], 6'h0, "cause cleared");
            u_core.end_op(6'h01 << s, s[3:0], {32'h0, 32'hC000_0000 | s}, tk);
            if (s < 5) fl[s] = 1'b1;
            chk(tk, s == 5, "taken only for unit error");
            chk(sc_rdata[17:12], 6'h01 << s, "cause bit");
            chk(sc_rdata[6:2], fl, "sticky flags");
            u_core.read(FBR_VIEW_SINGLE, s[3:0], 2'h0, 1'b0);
            chk(rd_data[31:0], (s == 5) ? wv(1'b0, 4'h5) : 32'hC000_0000 | s, "result write");
        end
        // Enabled invalid is taken, disabled divide by zero is not
        u_core.sc_store(32'h0000_0800, 1'b0);
        u_core.begin_op();
        u_core.end_op(6'h10, 4'h6, 64'h0000_0000_7777_7777, tk);
        chk({tk, sc_rdata}, {1'b1, 32'h0001_0840}, "enabled invalid");
        u_core.begin_op();
        u_core.end_op(6'h08, 4'h7, 64'h0000_0000_8888_8888, tk);
        chk({tk, sc_rdata}, {1'b0, 32'h0000_8860}, "disabled divide");
        u_core.read(FBR_VIEW_DOUBLE, 4'h6, 2'h0, 1'b0);
        chk(rd_data, {wv(1'b0, 4'h6), 32'h8888_8888}, "destinations");
        // Double-width result lands in an even/odd word pair
        u_core.sc_store(32'h0008_0000, 1'b0);
        u_core.begin_op();
        u_core.end_op(6'h00, 4'h9, 64'hDDDD_0000_EEEE_0000, tk);
        chk({tk, sc_rdata}, {1'b0, 32'h0008_0000}, "clean double op");
        u_core.read(FBR_VIEW_DOUBLE, 4'h8, 2'h0, 1'b0);
        chk(rd_data, 64'hDDDD_0000_EEEE_0000, "double result");
        // Transfer register from both sides, core wins a tie
        u_core.xfer(1'b1, 32'h1111_2222, 1'b0, 32'h0);
        chk(xfer_rdata, 32'h1111_2222, "core store");
        u_core.xfer(1'b0, 32'h0, 1'b1, 32'h3333_4444);
        chk(xfer_rdata, 32'h3333_4444, "unit store");
        u_core.xfer(1'b1, 32'h5555_6666, 1'b1, 32'h7777_8888);
        chk(xfer_rdata, 32'h5555_6666, "simultaneous store");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
